// ===== perf_qual_pkg.sv
// Constants and helpers for the cache and bus-queue event qualifier
package perf_qual_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int MASK_W = 16;
  localparam int REQ_W = 5;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] CREF_MASK_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] ALLOC_MASK_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] CREF_COUNT_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] ALLOC_COUNT_ADDR = 4'hC;

  localparam logic [MASK_W-1:0] MASK_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] COUNT_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] COUNT_ONE = 32'h00000001;

  // Cache-reference mask bit positions
  localparam int CREF_L2_HIT_S = 0;
  localparam int CREF_L3_HIT_S = 3;
  localparam int CREF_L2_MISS = 8;
  localparam int CREF_L3_MISS = 9;
  localparam int CREF_L2_WB_MISS = 10;

  // Bus-queue allocation mask field positions
  localparam int ALLOC_REQ_LO = 0;
  localparam int ALLOC_ALL_READ = 5;
  localparam int ALLOC_ALL_WRITE = 6;
  localparam int ALLOC_MEM_LO = 7;
  localparam int ALLOC_AGENT_LO = 13;
  localparam int ALLOC_READ_DEMAND = 15;

  // Line state codes from the cache pipeline
  typedef enum logic [1:0] {
    LINE_SHARED = 2'b00,
    LINE_EXCLUSIVE = 2'b01,
    LINE_MODIFIED = 2'b10,
    LINE_INVALID = 2'b11
  } line_state_type;

  // Any selected bit in a field matches the one-hot attribute
  function automatic logic field_match(input logic [REQ_W-1:0] sel, input logic [REQ_W-1:0] attr);
    field_match = |(sel & attr);
  endfunction

  function automatic logic [DATA_W-1:0] bump(input logic [DATA_W-1:0] v);
    bump = v + COUNT_ONE;
  endfunction
endpackage

// ===== alloc_qualifier.sv
// Qualification expression for bus-queue allocation entries
`timescale 1ns/10ps
module alloc_qualifier (
  input wire logic [perf_qual_pkg::MASK_W-1:0] mask,
  input wire logic [perf_qual_pkg::REQ_W-1:0] req_type,
  input wire logic is_read,
  input wire logic is_write,
  input wire logic read_demand,
  input wire logic [1:0] mem_type,
  input wire logic [1:0] src_agent,
  output logic qualify
);
  import perf_qual_pkg::*;

  logic req_hit;
  logic mem_hit;
  logic agent_hit;
  logic demand_ok;

  always_comb begin
    // Several bits set in one field OR their selections
    req_hit = field_match(mask[ALLOC_REQ_LO +: REQ_W], req_type);
    mem_hit = field_match({3'h0, mask[ALLOC_MEM_LO +: 2]}, {3'h0, mem_type});
    agent_hit = field_match({3'h0, mask[ALLOC_AGENT_LO +: 2]}, {3'h0, src_agent});
    // Demand filter only narrows reads; writes pass untouched
    demand_ok = !(mask[ALLOC_READ_DEMAND] && is_read && !read_demand);
    qualify = (req_hit || (mask[ALLOC_ALL_READ] && is_read) || (mask[ALLOC_ALL_WRITE] && is_write)
      || mem_hit) && agent_hit && demand_ok;
  end
endmodule // alloc_qualifier

// ===== cache_bus_event_qualifier.sv
// Cache-reference and bus-queue allocation event qualifier with counters
//
// Contract
// - Cache mask bits 0,1,2 count L2 read hits to shared, exclusive, modified lines.
// - Cache mask bits 3,4,5 count L3 read hits to shared, exclusive, modified lines.
// - Cache mask bit 8 counts L2 read misses; bit 9 counts L3 read misses.
// - Cache mask bit 10 counts writeback lookups missing the L2 cache.
// - Loads and ownership requests are both read-type accesses.
// - Prefetch or hit status is taken as seen in the evaluating cycle.
// - Allocation count rises once per qualifying bus queue allocation.
// - Sector or chunk allocations each count exactly once.
// - Every retry of a request is a fresh allocation and counts again.
// - Allocation mask bits 0-4 are one request-type field; set bits OR together.
// - Allocation mask bits 7 and 8 qualify target memory type.
// - Allocation mask bits 13 and 14 qualify the source agent.
// - Allocation mask bit 15 affects read transactions only.
// - Count when (request OR bit5 OR bit6 OR memory type) AND source agent.
// - Cache references are counted as seen at the bus unit.
`timescale 1ns/10ps
module cache_bus_event_qualifier (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [perf_qual_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [perf_qual_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [perf_qual_pkg::DATA_W-1:0] reg_rdata,
  input wire logic cref_valid,
  input wire logic cref_is_load,
  input wire logic cref_is_ownership,
  input wire logic cref_is_writeback,
  input wire logic cref_is_l3,
  input wire logic cref_hit,
  input wire logic [1:0] cref_line_state,
  input wire logic alloc_valid,
  input wire logic [perf_qual_pkg::REQ_W-1:0] alloc_req_type,
  input wire logic alloc_is_read,
  input wire logic alloc_is_write,
  input wire logic alloc_read_demand,
  input wire logic [1:0] alloc_mem_type,
  input wire logic [1:0] alloc_src_agent,
  output logic cref_event_q,
  output logic alloc_event_q
);
  import perf_qual_pkg::*;

  logic [MASK_W-1:0] cref_mask_q;
  logic [MASK_W-1:0] alloc_mask_q;
  logic [DATA_W-1:0] cref_count_q;
  logic [DATA_W-1:0] alloc_count_q;
  logic [DATA_W-1:0] reg_rdata_q;
  logic cref_read;
  logic cref_sel;
  logic alloc_qual;
  logic alloc_sel;
  logic cref_count_wr;
  logic alloc_count_wr;
  logic [1:0] hit_base;

  assign reg_rdata = reg_rdata_q;

  // Cache-reference classification, taken from the event as it stands now
  always_comb begin
    cref_read = cref_is_load || cref_is_ownership;
    hit_base = 2'b00;
    cref_sel = 1'b0;
    if (cref_valid) begin
      if (cref_is_writeback) begin
        cref_sel = !cref_is_l3 && !cref_hit && cref_mask_q[CREF_L2_WB_MISS];
      end else if (cref_read && !cref_hit) begin
        cref_sel = cref_is_l3 ? cref_mask_q[CREF_L3_MISS] : cref_mask_q[CREF_L2_MISS];
      end else if (cref_read) begin
        case (line_state_type'(cref_line_state))
          LINE_SHARED: hit_base = 2'h0;
          LINE_EXCLUSIVE: hit_base = 2'h1;
          LINE_MODIFIED: hit_base = 2'h2;
          default: hit_base = 2'h3;
        endcase
        if (hit_base != 2'h3) begin
          if (cref_is_l3) begin
            cref_sel = cref_mask_q[CREF_L3_HIT_S + int'(hit_base)];
          end else begin
            cref_sel = cref_mask_q[CREF_L2_HIT_S + int'(hit_base)];
          end
        end
      end
    end
  end

  alloc_qualifier u_alloc_qualifier (
    .mask(alloc_mask_q),
    .req_type(alloc_req_type),
    .is_read(alloc_is_read),
    .is_write(alloc_is_write),
    .read_demand(alloc_read_demand),
    .mem_type(alloc_mem_type),
    .src_agent(alloc_src_agent),
    .qualify(alloc_qual)
  );

  // Retries arrive as new allocations; size is not an input at all
  assign alloc_sel = alloc_valid && alloc_qual;

  assign cref_count_wr = reg_wr && (reg_addr == CREF_COUNT_ADDR);
  assign alloc_count_wr = reg_wr && (reg_addr == ALLOC_COUNT_ADDR);

  // Mask registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cref_mask_q <= MASK_RESET;
      alloc_mask_q <= MASK_RESET;
    end else if (reg_wr) begin
      if (reg_addr == CREF_MASK_ADDR) begin
        cref_mask_q <= reg_wdata[MASK_W-1:0];
      end
      if (reg_addr == ALLOC_MASK_ADDR) begin
        alloc_mask_q <= reg_wdata[MASK_W-1:0];
      end
    end
  end

  // Counters; a software load takes priority over an increment
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cref_count_q <= COUNT_RESET;
    end else if (cref_count_wr) begin
      cref_count_q <= reg_wdata;
    end else if (cref_sel) begin
      cref_count_q <= bump(cref_count_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      alloc_count_q <= COUNT_RESET;
    end else if (alloc_count_wr) begin
      alloc_count_q <= reg_wdata;
    end else if (alloc_sel) begin
      alloc_count_q <= bump(alloc_count_q);
    end
  end

  // Event pulses, one cycle after qualification
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cref_event_q <= 1'b0;
      alloc_event_q <= 1'b0;
    end else begin
      cref_event_q <= cref_sel;
      alloc_event_q <= alloc_sel;
    end
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata_q <= COUNT_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        CREF_MASK_ADDR: reg_rdata_q <= {{(DATA_W-MASK_W){1'b0}}, cref_mask_q};
        ALLOC_MASK_ADDR: reg_rdata_q <= {{(DATA_W-MASK_W){1'b0}}, alloc_mask_q};
        CREF_COUNT_ADDR: reg_rdata_q <= cref_count_q;
        ALLOC_COUNT_ADDR: reg_rdata_q <= alloc_count_q;
        default: reg_rdata_q <= COUNT_RESET;
      endcase
    end else begin
      reg_rdata_q <= COUNT_RESET;
    end
  end

  a_cref_count_step: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_sel && !cref_count_wr) |=> (cref_count_q == $past(cref_count_q) + COUNT_ONE))
    else $error("cache count did not step by one");

  a_cref_count_hold: assert property (@(posedge mclk) disable iff (!nrst)
    (!cref_sel && !cref_count_wr) |=> $stable(cref_count_q))
    else $error("cache count moved without event");

  a_l2_hit_shared: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && cref_is_load && !cref_is_writeback && cref_hit && !cref_is_l3
     && cref_line_state == 2'b00 && cref_mask_q[0]) |-> cref_sel)
    else $error("L2 shared hit not selected");

  a_l3_hit_modified: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && cref_is_ownership && !cref_is_writeback && cref_hit && cref_is_l3
     && cref_line_state == 2'b10) |-> (cref_sel == cref_mask_q[5]))
    else $error("L3 modified hit selection wrong");

  a_read_misses: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && cref_is_load && !cref_is_writeback && !cref_hit)
    |-> (cref_sel == (cref_is_l3 ? cref_mask_q[9] : cref_mask_q[8])))
    else $error("read miss selection wrong");

  a_wb_miss_sel: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && cref_is_writeback && !cref_is_l3 && !cref_hit)
    |-> (cref_sel == cref_mask_q[10]))
    else $error("writeback miss selection wrong");

  a_nonread_idle: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && !cref_is_load && !cref_is_ownership && !cref_is_writeback) |-> !cref_sel)
    else $error("non-read access counted");

  a_alloc_step: assert property (@(posedge mclk) disable iff (!nrst)
    (alloc_valid && alloc_qual && !alloc_count_wr)
    |=> (alloc_count_q == $past(alloc_count_q) + COUNT_ONE) && alloc_event_q)
    else $error("allocation count did not step");

  a_agent_gate: assert property (@(posedge mclk) disable iff (!nrst)
    (alloc_valid && !(|(alloc_mask_q[14:13] & alloc_src_agent)) && !alloc_count_wr)
    |=> $stable(alloc_count_q))
    else $error("allocation counted without agent match");

  a_all_read_term: assert property (@(posedge mclk) disable iff (!nrst)
    (alloc_valid && alloc_is_read && alloc_mask_q[5] && !alloc_mask_q[15]
     && |(alloc_mask_q[14:13] & alloc_src_agent)) |-> alloc_sel)
    else $error("read entry not counted with bit 5");

  a_read_data: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_rd && reg_addr == ALLOC_MASK_ADDR && !reg_wr)
    |=> (reg_rdata == {16'h0000, $past(alloc_mask_q)}))
    else $error("mask readback wrong");

  a_l2_hit_excl: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && (cref_is_load || cref_is_ownership) && !cref_is_writeback && cref_hit
     && !cref_is_l3 && cref_line_state == 2'b01)
    |-> (cref_sel == cref_mask_q[CREF_L2_HIT_S + 1]))
    else $error("L2 exclusive hit selection wrong");

  a_l2_hit_mod: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && (cref_is_load || cref_is_ownership) && !cref_is_writeback && cref_hit
     && !cref_is_l3 && cref_line_state == 2'b10)
    |-> (cref_sel == cref_mask_q[CREF_L2_HIT_S + 2]))
    else $error("L2 modified hit selection wrong");

  a_l3_hit_shared: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && (cref_is_load || cref_is_ownership) && !cref_is_writeback && cref_hit
     && cref_is_l3 && cref_line_state == 2'b00)
    |-> (cref_sel == cref_mask_q[CREF_L3_HIT_S]))
    else $error("L3 shared hit selection wrong");

  a_l3_hit_excl: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && (cref_is_load || cref_is_ownership) && !cref_is_writeback && cref_hit
     && cref_is_l3 && cref_line_state == 2'b01)
    |-> (cref_sel == cref_mask_q[CREF_L3_HIT_S + 1]))
    else $error("L3 exclusive hit selection wrong");

  a_invalid_line: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && (cref_is_load || cref_is_ownership) && !cref_is_writeback && cref_hit
     && cref_line_state == 2'b11) |-> !cref_sel)
    else $error("hit on invalid line counted");

  a_ownership_miss: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && cref_is_ownership && !cref_is_writeback && !cref_hit)
    |-> (cref_sel == (cref_is_l3 ? cref_mask_q[CREF_L3_MISS] : cref_mask_q[CREF_L2_MISS])))
    else $error("ownership miss selection wrong");

  a_wb_other_idle: assert property (@(posedge mclk) disable iff (!nrst)
    (cref_valid && cref_is_writeback && (cref_is_l3 || cref_hit)) |-> !cref_sel)
    else $error("writeback hit or L3 writeback counted");

  a_idle_no_count: assert property (@(posedge mclk) disable iff (!nrst)
    !cref_valid |-> !cref_sel)
    else $error("cache event selected without valid");

  a_cref_pulse: assert property (@(posedge mclk) disable iff (!nrst)
    cref_sel |=> cref_event_q)
    else $error("cache event pulse missing");

  a_cref_quiet: assert property (@(posedge mclk) disable iff (!nrst)
    !cref_sel |=> !cref_event_q)
    else $error("cache event pulse without event");

  a_alloc_quiet: assert property (@(posedge mclk) disable iff (!nrst)
    !alloc_sel |=> !alloc_event_q)
    else $error("allocation pulse without event");

  a_alloc_hold: assert property (@(posedge mclk) disable iff (!nrst)
    (!alloc_valid && !alloc_count_wr) |=> $stable(alloc_count_q))
    else $error("allocation count moved without valid");

  a_req_field: assert property (@(posedge mclk) disable iff (!nrst)
    (alloc_valid && |(alloc_mask_q[ALLOC_REQ_LO +: REQ_W] & alloc_req_type)
     && |(alloc_mask_q[ALLOC_AGENT_LO +: 2] & alloc_src_agent)
     && !(alloc_mask_q[ALLOC_READ_DEMAND] && alloc_is_read && !alloc_read_demand))
    |-> alloc_sel)
    else $error("request type match not counted");

  a_mem_field: assert property (@(posedge mclk) disable iff (!nrst)
    (alloc_valid && |(alloc_mask_q[ALLOC_MEM_LO +: 2] & alloc_mem_type)
     && |(alloc_mask_q[ALLOC_AGENT_LO +: 2] & alloc_src_agent)
     && !(alloc_mask_q[ALLOC_READ_DEMAND] && alloc_is_read && !alloc_read_demand))
    |-> alloc_sel)
    else $error("memory type match not counted");

  a_all_write_term: assert property (@(posedge mclk) disable iff (!nrst)
    (alloc_valid && alloc_is_write && !alloc_is_read && alloc_mask_q[ALLOC_ALL_WRITE]
     && |(alloc_mask_q[ALLOC_AGENT_LO +: 2] & alloc_src_agent)) |-> alloc_sel)
    else $error("write entry not counted with bit 6");

  a_demand_filter: assert property (@(posedge mclk) disable iff (!nrst)
    (alloc_valid && alloc_is_read && alloc_mask_q[ALLOC_READ_DEMAND] && !alloc_read_demand)
    |-> !alloc_sel)
    else $error("non-demand read counted under bit 15");

  a_count_load: assert property (@(posedge mclk) disable iff (!nrst)
    cref_count_wr |=> (cref_count_q == $past(reg_wdata)))
    else $error("cache count load wrong");

  a_rdata_idle: assert property (@(posedge mclk) disable iff (!nrst)
    !reg_rd |=> (reg_rdata == COUNT_RESET))
    else $error("read data not zero without read");
endmodule // cache_bus_event_qualifier

// ===== pipe_model.sv
// Behavioural cache pipeline and bus queue feeding event indications
`timescale 1ns/10ps
module pipe_model (
  input wire logic mclk,
  output logic cref_valid,
  output logic [6:0] cref_attr,
  output logic alloc_valid,
  output logic [11:0] alloc_attr
);
  initial begin
    cref_valid = 1'b0;
    cref_attr = 7'h00;
    alloc_valid = 1'b0;
    alloc_attr = 12'h000;
  end

  // Load, ownership, writeback, l3, hit, line state
  task automatic cref_drive(input logic [6:0] ev);
    cref_valid <= 1'b1;
    cref_attr <= ev;
    @(posedge mclk);
  endtask

  // Attributes are junk outside a valid cycle, not the last value
  task automatic cref_idle();
    cref_valid <= 1'b0;
    cref_attr <= ~cref_attr;
  endtask

  // Request type, read, write, demand, memory type, agent
  task automatic alloc_drive(input logic [11:0] a);
    alloc_valid <= 1'b1;
    alloc_attr <= a;
    @(posedge mclk);
  endtask

  task automatic alloc_idle();
    alloc_valid <= 1'b0;
    alloc_attr <= ~alloc_attr;
  endtask
endmodule // pipe_model

// ===== cache_bus_event_qualifier_tb_top.sv
// Register-level tests of the cache and bus-queue event qualifier
`timescale 1ns/10ps
module cache_bus_event_qualifier_tb_top;
  import perf_qual_pkg::*;
  logic mclk, nrst, reg_wr, reg_rd, cref_valid, alloc_valid, cref_event_q, alloc_event_q;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, exp_alloc;
  logic [6:0] cref_attr;
  logic [11:0] alloc_attr;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // Last entry is a hit that is neither load nor ownership: never counted
  localparam logic [11:0][6:0] CREF_EVS = {7'b1000100, 7'b0100101, 7'b1000110,
    7'b0101100, 7'b1001101, 7'b0101110, 7'b1000000, 7'b0101000, 7'b0010000,
    7'b1000111, 7'b0010100, 7'b0000100};
  localparam logic [8:0][4:0] CREF_BITS = {5'h0, 5'h1, 5'h2, 5'h3, 5'h4, 5'h5, 5'h8, 5'h9,
    5'hA};

  cache_bus_event_qualifier i_cache_bus_event_qualifier (.mclk(mclk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cref_valid(cref_valid), .cref_is_load(cref_attr[6]),
    .cref_is_ownership(cref_attr[5]), .cref_is_writeback(cref_attr[4]),
    .cref_is_l3(cref_attr[3]), .cref_hit(cref_attr[2]), .cref_line_state(cref_attr[1:0]),
    .alloc_valid(alloc_valid), .alloc_req_type(alloc_attr[11:7]),
    .alloc_is_read(alloc_attr[6]), .alloc_is_write(alloc_attr[5]),
    .alloc_read_demand(alloc_attr[4]), .alloc_mem_type(alloc_attr[3:2]),
    .alloc_src_agent(alloc_attr[1:0]), .cref_event_q(cref_event_q),
    .alloc_event_q(alloc_event_q));

  pipe_model i_pipe_model (.mclk(mclk), .cref_valid(cref_valid), .cref_attr(cref_attr),
    .alloc_valid(alloc_valid), .alloc_attr(alloc_attr));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Run is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // Data stand one cycle only; look mid-cycle, leave on a rising edge
    @(negedge mclk);
    cmp_word(reg_rdata, exp);
    @(posedge mclk);
  endtask

  task automatic cref_run(input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] exp);
    wr(CREF_COUNT_ADDR, COUNT_RESET);
    wr(CREF_MASK_ADDR, m);
    for (int j = 0; j < 12; j++) begin
      i_pipe_model.cref_drive(CREF_EVS[j]);
    end
    i_pipe_model.cref_idle();
    rd(CREF_COUNT_ADDR, exp);
  endtask

  task automatic acase(input logic [15:0] m, input logic [11:0] a, input logic e);
    wr(ALLOC_MASK_ADDR, {16'h0000, m});
    i_pipe_model.alloc_drive(a);
    i_pipe_model.alloc_idle();
    @(negedge mclk);
    cmp_bit(alloc_event_q, e);
    @(posedge mclk);
    exp_alloc = exp_alloc + {31'h0, e};
  endtask

  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h00000000;
    exp_alloc = 32'h00000000;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd(CREF_MASK_ADDR, COUNT_RESET);
    rd(ALLOC_COUNT_ADDR, COUNT_RESET);
    rd(4'h2, COUNT_RESET);
    wr(ALLOC_MASK_ADDR, 32'hFFFF1234);
    rd(ALLOC_MASK_ADDR, 32'h00001234);
    for (int i = 0; i < 9; i++) begin
      cref_run(COUNT_ONE << CREF_BITS[i], COUNT_ONE);
    end
    cref_run(32'h0000073F, 32'h00000009);
    i_pipe_model.cref_drive(7'b1000100);
    i_pipe_model.cref_idle();
    @(negedge mclk);
    cmp_bit(cref_event_q, 1'b1);
    @(negedge mclk);
    cmp_bit(cref_event_q, 1'b0);
    @(posedge mclk);
    wr(ALLOC_COUNT_ADDR, COUNT_RESET);
    acase(16'h2001, {5'h01, 3'b100, 2'h0, 2'h1}, 1'b1);
    acase(16'h2006, {5'h04, 3'b010, 2'h0, 2'h1}, 1'b1);
    acase(16'h2006, {5'h01, 3'b100, 2'h0, 2'h1}, 1'b0);
    acase(16'h2001, {5'h01, 3'b100, 2'h0, 2'h2}, 1'b0);
    acase(16'h6001, {5'h01, 3'b100, 2'h0, 2'h2}, 1'b1);
    acase(16'h4020, {5'h00, 3'b100, 2'h0, 2'h2}, 1'b1);
    acase(16'h4020, {5'h00, 3'b010, 2'h0, 2'h2}, 1'b0);
    acase(16'h4040, {5'h00, 3'b010, 2'h0, 2'h2}, 1'b1);
    acase(16'h2080, {5'h00, 3'b010, 2'h1, 2'h1}, 1'b1);
    acase(16'h2080, {5'h00, 3'b010, 2'h2, 2'h1}, 1'b0);
    acase(16'h2100, {5'h00, 3'b010, 2'h2, 2'h1}, 1'b1);
    acase(16'hA020, {5'h00, 3'b100, 2'h0, 2'h1}, 1'b0);
    acase(16'hA020, {5'h00, 3'b101, 2'h0, 2'h1}, 1'b1);
    acase(16'hA040, {5'h00, 3'b010, 2'h0, 2'h1}, 1'b1);
    // Retries arrive back to back with no idle cycle between
    i_pipe_model.alloc_drive({5'h00, 3'b010, 2'h0, 2'h1});
    i_pipe_model.alloc_drive({5'h00, 3'b010, 2'h0, 2'h1});
    i_pipe_model.alloc_idle();
    exp_alloc = exp_alloc + 32'h00000002;
    rd(ALLOC_COUNT_ADDR, exp_alloc);
    // Second reset in mid-run must clear counts and masks again
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd(CREF_COUNT_ADDR, COUNT_RESET);
    rd(ALLOC_MASK_ADDR, COUNT_RESET);
    rd(ALLOC_COUNT_ADDR, COUNT_RESET);
    summarize();
  end
endmodule // cache_bus_event_qualifier_tb_top
